// File: hw/fao_pkg.sv
// Constants, types and register map of the frequency arrival and logic output block
// Operation
// - Accelerating: overreach A sets once frequency exceeds accel threshold A (0-590.00 Hz).
// - Decelerating: overreach A clears once frequency falls below decel threshold A.
// - Overreach B behaves identically with its own accel and decel thresholds.
// - Terminal code 02 carries overreach A, code 24 carries overreach B.
// - Accelerating: arrival A asserts when frequency reaches accel threshold A.
// - Decelerating: arrival A asserts when frequency reaches decel threshold A.
// - Arrival B behaves the same using the B threshold pair.
// - Terminal code 06 carries arrival A, code 25 carries arrival B.
// - Zero-speed flag set below zero-speed level (0-100.00 Hz); terminal code 21.
// - Zero-speed flag always set while frequency is zero, even with a zero-speed level of 0.
// - With encoder feedback, zero-speed uses measured motor speed instead.
// - Three combiners, two operands each; operator 00 AND, 01 OR, 02 XOR.
// - Operand codes 00 to 62 allowed, except 33 to 35 and 63.
// - No combiner result may be an operand of a combiner.
// - Terminal codes 33, 34, 35 carry combiner results 1, 2, 3.
// - Three output terminals, each with its own function-code selector.
package fao_pkg;

   // Frequencies in 0.01 Hz units
   localparam int FREQ_W = 16;
   localparam logic [15:0] FREQ_MAX = 16'hE678;      // 590.00 Hz
   localparam logic [15:0] ZERO_LEVEL_MAX = 16'h2710; // 100.00 Hz
   localparam int CODE_W = 6;
   localparam int NUM_CODES = 64;

   // Function codes
   localparam logic [5:0] CODE_OVER_A = 6'h02;
   localparam logic [5:0] CODE_ARRIVE_A = 6'h06;
   localparam logic [5:0] CODE_ZERO = 6'h15;
   localparam logic [5:0] CODE_OVER_B = 6'h18;
   localparam logic [5:0] CODE_ARRIVE_B = 6'h19;
   localparam logic [5:0] CODE_COMB1 = 6'h21;
   localparam logic [5:0] CODE_COMB3 = 6'h23;
   localparam logic [5:0] CODE_NONE = 6'h3F;

   // Combiner operators
   localparam logic [1:0] OP_AND = 2'h0;
   localparam logic [1:0] OP_OR = 2'h1;
   localparam logic [1:0] OP_XOR = 2'h2;

   // Register byte offsets
   localparam logic [7:0] REG_ACCEL_A = 8'h00;
   localparam logic [7:0] REG_DECEL_A = 8'h04;
   localparam logic [7:0] REG_ACCEL_B = 8'h08;
   localparam logic [7:0] REG_DECEL_B = 8'h0C;
   localparam logic [7:0] REG_ZERO_LEVEL = 8'h10;
   localparam logic [7:0] REG_ARRIVE_TOL = 8'h14;
   localparam logic [7:0] REG_TERM_SEL = 8'h18;
   localparam logic [7:0] REG_COMB1 = 8'h1C;
   localparam logic [7:0] REG_COMB2 = 8'h20;
   localparam logic [7:0] REG_COMB3 = 8'h24;
   localparam logic [7:0] REG_CTRL = 8'h28;
   localparam logic [7:0] REG_FLAGS = 8'h2C;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h30;
   localparam logic [7:0] REG_IRQ_MASK = 8'h34;

   // Field positions
   localparam int TERM1_LSB = 0;
   localparam int TERM2_LSB = 8;
   localparam int TERM3_LSB = 16;
   localparam int OPA_LSB = 0;
   localparam int OPB_LSB = 8;
   localparam int OPER_LSB = 16;
   localparam int CTRL_ENC_BIT = 0;
   localparam int NUM_EVT = 5;

   // Reset values
   localparam logic [15:0] RST_THRESHOLD = 16'h0000;
   localparam logic [15:0] RST_ZERO_LEVEL = 16'h0000;
   localparam logic [15:0] RST_ARRIVE_TOL = 16'h0032; // 0.50 Hz
   localparam logic [5:0] RST_TERM_SEL = 6'h3F;
   localparam logic [5:0] RST_OPERAND = 6'h00;
   localparam logic [1:0] RST_OPERATOR = 2'h0;

   typedef struct packed {
      logic [5:0] opa;
      logic [5:0] opb;
      logic [1:0] oper;
   } fao_comb_t;

   typedef struct packed {
      logic [15:0] accel_a;
      logic [15:0] decel_a;
      logic [15:0] accel_b;
      logic [15:0] decel_b;
      logic [15:0] zero_level;
      logic [15:0] arrive_tol;
      logic [5:0] term1;
      logic [5:0] term2;
      logic [5:0] term3;
      fao_comb_t comb1;
      fao_comb_t comb2;
      fao_comb_t comb3;
      logic enc_en;
   } fao_cfg_t;

   // Flag bit order in status and interrupt registers
   typedef struct packed {
      logic zero_speed;
      logic arrival_b;
      logic arrival_a;
      logic overreach_b;
      logic overreach_a;
   } fao_flags_t;

endpackage

// File: hw/fao_top.sv
// Frequency arrival flags, logic combiners and terminal selectors with APB registers
`timescale 1ns/1ps
module fao_top
   import fao_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Drive state
   input wire logic [15:0] out_freq_in,
   input wire logic [15:0] motor_speed_in,
   input wire logic accelerating_in,
   input wire logic decelerating_in,
   input wire logic [63:0] other_signals_in,
   // Terminals and interrupt
   output logic [2:0] terminal_out,
   output logic irq_out
);

   // ==========================================
   // Reset synchroniser
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // ==========================================
   // Flag logic
   fao_cfg_t cfg_q;
   fao_flags_t flags_q;
   fao_flags_t flags_d;
   logic [15:0] zero_ref_freq;
   logic [16:0] diff_acc_a;
   logic [16:0] diff_dec_a;
   logic [16:0] diff_acc_b;
   logic [16:0] diff_dec_b;

   function automatic logic [16:0] absdiff(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] r;
      r = (a >= b) ? {1'b0, a - b} : {1'b0, b - a};
      return r;
   endfunction

   always_comb begin
      flags_d = flags_q;
      diff_acc_a = absdiff(out_freq_in, cfg_q.accel_a);
      diff_dec_a = absdiff(out_freq_in, cfg_q.decel_a);
      diff_acc_b = absdiff(out_freq_in, cfg_q.accel_b);
      diff_dec_b = absdiff(out_freq_in, cfg_q.decel_b);
      // Overreach: set on accel above, clear on decel below, else hold
      if (accelerating_in && (out_freq_in > cfg_q.accel_a)) begin
         flags_d.overreach_a = 1'b1;
      end else if (decelerating_in && (out_freq_in < cfg_q.decel_a)) begin
         flags_d.overreach_a = 1'b0;
      end
      if (accelerating_in && (out_freq_in > cfg_q.accel_b)) begin
         flags_d.overreach_b = 1'b1;
      end else if (decelerating_in && (out_freq_in < cfg_q.decel_b)) begin
         flags_d.overreach_b = 1'b0;
      end
      // Arrival: within tolerance band of the active threshold only
      if (accelerating_in) begin
         flags_d.arrival_a = (diff_acc_a <= {1'b0, cfg_q.arrive_tol});
         flags_d.arrival_b = (diff_acc_b <= {1'b0, cfg_q.arrive_tol});
      end else if (decelerating_in) begin
         flags_d.arrival_a = (diff_dec_a <= {1'b0, cfg_q.arrive_tol});
         flags_d.arrival_b = (diff_dec_b <= {1'b0, cfg_q.arrive_tol});
      end else begin
         flags_d.arrival_a = 1'b0;
         flags_d.arrival_b = 1'b0;
      end
      zero_ref_freq = cfg_q.enc_en ? motor_speed_in : out_freq_in;
      flags_d.zero_speed = (zero_ref_freq < cfg_q.zero_level) ||
                           (zero_ref_freq == 16'h0000);
   end

   always_ff @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   // ==========================================
   // Signal map, combiners and terminal selection
   logic [63:0] base_sig;
   logic [63:0] all_sig;
   logic [2:0] comb_res;
   fao_comb_t combs [3];
   logic [2:0] terminal_d;
   logic [2:0] terminal_q;

   always_comb begin
      // Combiner result codes are forced low here so they never feed a combiner
      base_sig = other_signals_in;
      base_sig[CODE_OVER_A] = flags_q.overreach_a;
      base_sig[CODE_OVER_B] = flags_q.overreach_b;
      base_sig[CODE_ARRIVE_A] = flags_q.arrival_a;
      base_sig[CODE_ARRIVE_B] = flags_q.arrival_b;
      base_sig[CODE_ZERO] = flags_q.zero_speed;
      base_sig[CODE_COMB1] = 1'b0;
      base_sig[CODE_COMB1 + 6'h01] = 1'b0;
      base_sig[CODE_COMB3] = 1'b0;
      base_sig[CODE_NONE] = 1'b0;
      combs[0] = cfg_q.comb1;
      combs[1] = cfg_q.comb2;
      combs[2] = cfg_q.comb3;
      for (int i = 0; i < 3; i++) begin
         unique case (combs[i].oper)
            OP_AND: comb_res[i] = base_sig[combs[i].opa] & base_sig[combs[i].opb];
            OP_OR: comb_res[i] = base_sig[combs[i].opa] | base_sig[combs[i].opb];
            OP_XOR: comb_res[i] = base_sig[combs[i].opa] ^ base_sig[combs[i].opb];
            default: comb_res[i] = 1'b0;
         endcase
      end
      all_sig = base_sig;
      all_sig[CODE_COMB1] = comb_res[0];
      all_sig[CODE_COMB1 + 6'h01] = comb_res[1];
      all_sig[CODE_COMB3] = comb_res[2];
      terminal_d[0] = all_sig[cfg_q.term1];
      terminal_d[1] = all_sig[cfg_q.term2];
      terminal_d[2] = all_sig[cfg_q.term3];
   end

   always_ff @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         terminal_q <= '0;
      end else begin
         terminal_q <= terminal_d;
      end
   end

   // ==========================================
   // APB register file
   fao_cfg_t cfg_d;
   fao_flags_t irq_stat_q;
   fao_flags_t irq_stat_d;
   fao_flags_t irq_mask_q;
   fao_flags_t irq_mask_d;
   fao_flags_t rise;
   logic irq_d;
   logic irq_q;
   logic [31:0] prdata_d;
   logic [31:0] prdata_q;
   logic pready_d;
   logic pready_q;
   logic err_d;
   logic err_q;
   logic setup;
   logic wr_en;
   logic [15:0] wfreq;
   fao_comb_t wcomb;

   function automatic logic operand_ok(input logic [5:0] c);
      return !((c >= CODE_COMB1) && (c <= CODE_COMB3)) && (c != CODE_NONE);
   endfunction

   function automatic logic [31:0] comb_word(input fao_comb_t c);
      logic [31:0] w;
      w = '0;
      w[OPA_LSB +: CODE_W] = c.opa;
      w[OPB_LSB +: CODE_W] = c.opb;
      w[OPER_LSB +: 2] = c.oper;
      return w;
   endfunction

   always_comb begin
      setup = psel_in && !penable_in;
      wfreq = pwdata_in[15:0];
      wcomb.opa = pwdata_in[OPA_LSB +: CODE_W];
      wcomb.opb = pwdata_in[OPB_LSB +: CODE_W];
      wcomb.oper = pwdata_in[OPER_LSB +: 2];
      // Read data and error decided in the setup cycle
      prdata_d = prdata_q;
      err_d = err_q;
      pready_d = setup;
      if (setup) begin
         prdata_d = '0;
         err_d = 1'b0;
         unique case (paddr_in)
            REG_ACCEL_A: prdata_d[15:0] = cfg_q.accel_a;
            REG_DECEL_A: prdata_d[15:0] = cfg_q.decel_a;
            REG_ACCEL_B: prdata_d[15:0] = cfg_q.accel_b;
            REG_DECEL_B: prdata_d[15:0] = cfg_q.decel_b;
            REG_ZERO_LEVEL: prdata_d[15:0] = cfg_q.zero_level;
            REG_ARRIVE_TOL: prdata_d[15:0] = cfg_q.arrive_tol;
            REG_TERM_SEL: begin
               prdata_d[TERM1_LSB +: CODE_W] = cfg_q.term1;
               prdata_d[TERM2_LSB +: CODE_W] = cfg_q.term2;
               prdata_d[TERM3_LSB +: CODE_W] = cfg_q.term3;
            end
            REG_COMB1: prdata_d = comb_word(cfg_q.comb1);
            REG_COMB2: prdata_d = comb_word(cfg_q.comb2);
            REG_COMB3: prdata_d = comb_word(cfg_q.comb3);
            REG_CTRL: prdata_d[CTRL_ENC_BIT] = cfg_q.enc_en;
            REG_FLAGS: prdata_d[NUM_EVT-1:0] = flags_q;
            REG_IRQ_STATUS: prdata_d[NUM_EVT-1:0] = irq_stat_q;
            REG_IRQ_MASK: prdata_d[NUM_EVT-1:0] = irq_mask_q;
            default: err_d = 1'b1;
         endcase
         // Out-of-range settings are refused with an error and not stored
         if (pwrite_in) begin
            unique case (paddr_in)
               REG_ACCEL_A, REG_DECEL_A, REG_ACCEL_B, REG_DECEL_B:
                  err_d = (wfreq > FREQ_MAX);
               REG_ZERO_LEVEL: err_d = (wfreq > ZERO_LEVEL_MAX);
               REG_COMB1, REG_COMB2, REG_COMB3:
                  err_d = !operand_ok(wcomb.opa) || !operand_ok(wcomb.opb) ||
                          (wcomb.oper > OP_XOR);
               REG_FLAGS: err_d = 1'b1;
               default: ;
            endcase
         end
      end
      wr_en = psel_in && penable_in && pwrite_in && pready_q && !err_q;
      // Configuration updates
      cfg_d = cfg_q;
      irq_mask_d = irq_mask_q;
      if (wr_en) begin
         unique case (paddr_in)
            REG_ACCEL_A: cfg_d.accel_a = wfreq;
            REG_DECEL_A: cfg_d.decel_a = wfreq;
            REG_ACCEL_B: cfg_d.accel_b = wfreq;
            REG_DECEL_B: cfg_d.decel_b = wfreq;
            REG_ZERO_LEVEL: cfg_d.zero_level = wfreq;
            REG_ARRIVE_TOL: cfg_d.arrive_tol = wfreq;
            REG_TERM_SEL: begin
               cfg_d.term1 = pwdata_in[TERM1_LSB +: CODE_W];
               cfg_d.term2 = pwdata_in[TERM2_LSB +: CODE_W];
               cfg_d.term3 = pwdata_in[TERM3_LSB +: CODE_W];
            end
            REG_COMB1: cfg_d.comb1 = wcomb;
            REG_COMB2: cfg_d.comb2 = wcomb;
            REG_COMB3: cfg_d.comb3 = wcomb;
            REG_CTRL: cfg_d.enc_en = pwdata_in[CTRL_ENC_BIT];
            REG_IRQ_MASK: irq_mask_d = pwdata_in[NUM_EVT-1:0];
            default: ;
         endcase
      end
      // Sticky events on rising flags; a set in the clear cycle wins
      rise = flags_d & ~flags_q;
      irq_stat_d = irq_stat_q;
      if (wr_en && (paddr_in == REG_IRQ_STATUS)) begin
         irq_stat_d = irq_stat_q & ~pwdata_in[NUM_EVT-1:0];
      end
      irq_stat_d = irq_stat_d | rise;
      irq_d = |(irq_stat_d & irq_mask_d);
   end

   always_ff @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         cfg_q.accel_a <= RST_THRESHOLD;
         cfg_q.decel_a <= RST_THRESHOLD;
         cfg_q.accel_b <= RST_THRESHOLD;
         cfg_q.decel_b <= RST_THRESHOLD;
         cfg_q.zero_level <= RST_ZERO_LEVEL;
         cfg_q.arrive_tol <= RST_ARRIVE_TOL;
         cfg_q.term1 <= RST_TERM_SEL;
         cfg_q.term2 <= RST_TERM_SEL;
         cfg_q.term3 <= RST_TERM_SEL;
         cfg_q.comb1 <= '{RST_OPERAND, RST_OPERAND, RST_OPERATOR};
         cfg_q.comb2 <= '{RST_OPERAND, RST_OPERAND, RST_OPERATOR};
         cfg_q.comb3 <= '{RST_OPERAND, RST_OPERAND, RST_OPERATOR};
         cfg_q.enc_en <= 1'b0;
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         irq_q <= 1'b0;
         prdata_q <= '0;
         pready_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         irq_q <= irq_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         err_q <= err_d;
      end
   end

   // ==========================================
   // Outputs
   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = err_q;
   assign terminal_out = terminal_q;
   assign irq_out = irq_q;

endmodule

// File: verif/fao_checker.sv
// Port-level assertions for the frequency arrival and logic output block
`timescale 1ns/1ps
module fao_checker
   import fao_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // Drive state
   input wire logic [15:0] out_freq_in,
   input wire logic [15:0] motor_speed_in,
   input wire logic accelerating_in,
   input wire logic decelerating_in,
   input wire logic [63:0] other_signals_in,
   // Terminals and interrupt
   input wire logic [2:0] terminal_out,
   input wire logic irq_out
);
   // =========================================
   // Shadow of the selectors, encoder enable and mask
   logic [5:0] sel1_q, sel2_q, sel3_q;
   logic enc_q;
   logic [4:0] mask_q;
   logic commit;
   assign commit = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel1_q <= 6'h3F;
         sel2_q <= 6'h3F;
         sel3_q <= 6'h3F;
         enc_q <= 1'b0;
         mask_q <= 5'h00;
      end else if (commit) begin
         case (paddr_in)
            REG_TERM_SEL: begin
               sel1_q <= pwdata_in[TERM1_LSB +: 6];
               sel2_q <= pwdata_in[TERM2_LSB +: 6];
               sel3_q <= pwdata_in[TERM3_LSB +: 6];
            end
            REG_CTRL: enc_q <= pwdata_in[CTRL_ENC_BIT];
            REG_IRQ_MASK: mask_q <= pwdata_in[4:0];
            default: ;
         endcase
      end
   end
   // =========================================
   // Assertions
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   a_ready_one_cycle: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
      else $error("pready not a single cycle after setup");
   a_unmapped_refused: assert property (psel_in && !penable_in && paddr_in > REG_IRQ_MASK
      |=> pslverr_out && prdata_out == 32'h00000000)
      else $error("unmapped access not refused");
   a_irq_masked_off: assert property (mask_q == 5'h00 |=> !irq_out)
      else $error("interrupt raised with all sources masked");
   a_zero_at_rest: assert property (((enc_q ? motor_speed_in : out_freq_in) == 16'h0000)
      ##1 (sel1_q == CODE_ZERO) |=> terminal_out[0])
      else $error("zero speed flag low at zero speed");
   a_overreach_sets: assert property ((accelerating_in && out_freq_in == 16'hFFFF)
      ##1 (sel1_q == CODE_OVER_A) |=> terminal_out[0])
      else $error("overreach flag not set above threshold");
   a_overreach_holds: assert property ((!accelerating_in && !decelerating_in
      && sel2_q == CODE_OVER_B) ##1 (sel2_q == CODE_OVER_B) |=> $stable(terminal_out[1]))
      else $error("overreach flag changed while steady");
   a_arrival_idle: assert property ((!accelerating_in && !decelerating_in)
      ##1 (sel2_q == CODE_ARRIVE_A) |=> !terminal_out[1])
      else $error("arrival flag high while steady");
   a_terminal_off: assert property (sel3_q == CODE_NONE |=> !terminal_out[2])
      else $error("unselected terminal driven high");
endmodule

// File: verif/fao_supervisor.sv
// Supervisory controller model that samples the terminals and the interrupt line
`timescale 1ns/1ps
module fao_supervisor (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Device outputs
   input wire logic [2:0] terminal_in,
   input wire logic irq_in,
   // Sampled view
   output logic [2:0] terminal_seen_out,
   output logic irq_seen_out
);
   logic [2:0] term_q;
   logic irq_q;
   // Reads the terminals once per clock, as a polling controller would
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         term_q <= 3'h0;
         irq_q <= 1'b0;
      end else begin
         term_q <= terminal_in;
         irq_q <= irq_in;
      end
   end
   assign terminal_seen_out = term_q;
   assign irq_seen_out = irq_q;
endmodule

// File: verif/fao_top_tb.sv
// Self-checking testbench for the frequency arrival and logic output block
`timescale 1ns/1ps
module fao_top_tb;
   import fao_pkg::*;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, acc, dec, irq, irq_seen;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] freq, mspeed;
   logic [63:0] other;
   logic [2:0] term, term_seen;
   int errors = 0;
   int n_checks = 0;

   fao_top u_fao_top (.mclk_in(mclk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .out_freq_in(freq), .motor_speed_in(mspeed),
      .accelerating_in(acc), .decelerating_in(dec), .other_signals_in(other),
      .terminal_out(term), .irq_out(irq));
   fao_supervisor u_fao_supervisor (.mclk_in(mclk), .rst_n_in(rst_n), .terminal_in(term),
      .irq_in(irq), .terminal_seen_out(term_seen), .irq_seen_out(irq_seen));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // =========================================
   // Compare, bus and drive tasks
   task chk1(input string n, input logic e, input logic s);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %b seen %b", n, e, s);
      end
   endtask
   task chkw(input string n, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic x);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) errors++;
      r = prdata;
      x = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wreg(input logic [7:0] a, input logic [31:0] d, input logic e);
      logic [31:0] r;
      logic x;
      apb(1'b1, a, d, r, x);
      chk1("pslverr", e, x);
   endtask
   task rreg(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      logic x;
      apb(1'b0, a, 32'h00000000, r, x);
      chkw($sformatf("reg %h", a), e, r);
   endtask
   function automatic logic [31:0] tsel(input logic [5:0] t1, t2, t3);
      return {8'h00, 2'h0, t3, 2'h0, t2, 2'h0, t1};
   endfunction
   function automatic logic [31:0] comb(input logic [5:0] a, b, input logic [1:0] o);
      return {14'h0000, o, 2'h0, b, 2'h0, a};
   endfunction
   task settle;
      repeat (5) @(posedge mclk);
   endtask
   task drive(input logic [15:0] f, input logic a, input logic d);
      @(posedge mclk);
      freq <= f;
      acc <= a;
      dec <= d;
      settle();
   endtask
   // =========================================
   // Scenarios
   task test_reset;
      logic [31:0] r;
      logic x;
      rreg(REG_ARRIVE_TOL, 32'h00000032);
      rreg(REG_TERM_SEL, 32'h003F3F3F);
      rreg(REG_COMB1, 32'h00000000);
      apb(1'b0, 8'h40, 32'h00000000, r, x);
      chk1("unmapped err", 1'b1, x);
      chkw("unmapped data", 32'h00000000, r);
      wreg(REG_FLAGS, 32'h00000001, 1'b1);
      wreg(REG_ACCEL_A, 32'h0000E679, 1'b1);
      wreg(REG_ACCEL_A, 32'h0000E678, 1'b0);
      rreg(REG_ACCEL_A, 32'h0000E678);
      chk1("terminal3", 1'b0, term_seen[2]);
   endtask
   task test_overreach;
      wreg(REG_ACCEL_A, 32'h000003E8, 1'b0);
      wreg(REG_DECEL_A, 32'h000001F4, 1'b0);
      wreg(REG_ACCEL_B, 32'h000007D0, 1'b0);
      wreg(REG_DECEL_B, 32'h00000064, 1'b0);
      wreg(REG_TERM_SEL, tsel(CODE_OVER_A, CODE_OVER_B, CODE_NONE), 1'b0);
      drive(16'h03E8, 1'b1, 1'b0);
      chk1("over a", 1'b0, term_seen[0]);
      drive(16'h03E9, 1'b1, 1'b0);
      chk1("over a", 1'b1, term_seen[0]);
      chk1("over b", 1'b0, term_seen[1]);
      drive(16'h07D1, 1'b1, 1'b0);
      chk1("over b", 1'b1, term_seen[1]);
      drive(16'h0000, 1'b0, 1'b0);
      chk1("over a", 1'b1, term_seen[0]);
      drive(16'h01F4, 1'b0, 1'b1);
      chk1("over a", 1'b1, term_seen[0]);
      drive(16'h01F3, 1'b0, 1'b1);
      chk1("over a", 1'b0, term_seen[0]);
      chk1("over b", 1'b1, term_seen[1]);
      drive(16'h0063, 1'b0, 1'b1);
      chk1("over b", 1'b0, term_seen[1]);
   endtask
   task test_arrival;
      wreg(REG_TERM_SEL, tsel(CODE_ARRIVE_B, CODE_ARRIVE_A, CODE_NONE), 1'b0);
      drive(16'h041A, 1'b1, 1'b0);
      chk1("arrive a", 1'b1, term_seen[1]);
      chk1("arrive b", 1'b0, term_seen[0]);
      drive(16'h041B, 1'b1, 1'b0);
      chk1("arrive a", 1'b0, term_seen[1]);
      drive(16'h01C2, 1'b0, 1'b1);
      chk1("arrive a", 1'b1, term_seen[1]);
      drive(16'h0064, 1'b0, 1'b1);
      chk1("arrive b", 1'b1, term_seen[0]);
      chk1("arrive a", 1'b0, term_seen[1]);
      drive(16'h0064, 1'b0, 1'b0);
      chk1("arrive b", 1'b0, term_seen[0]);
   endtask
   task test_zero;
      wreg(REG_ZERO_LEVEL, 32'h00002711, 1'b1);
      wreg(REG_ZERO_LEVEL, 32'h0000012C, 1'b0);
      wreg(REG_TERM_SEL, tsel(CODE_ZERO, CODE_NONE, CODE_NONE), 1'b0);
      drive(16'h012B, 1'b0, 1'b1);
      chk1("zero", 1'b1, term_seen[0]);
      drive(16'h012C, 1'b0, 1'b1);
      chk1("zero", 1'b0, term_seen[0]);
      wreg(REG_ZERO_LEVEL, 32'h00000000, 1'b0);
      drive(16'h0000, 1'b0, 1'b0);
      chk1("zero", 1'b1, term_seen[0]);
      wreg(REG_CTRL, 32'h00000001, 1'b0);
      mspeed <= 16'h01F4;
      drive(16'h0000, 1'b0, 1'b0);
      chk1("zero enc", 1'b0, term_seen[0]);
      mspeed <= 16'h0000;
      drive(16'h01F4, 1'b0, 1'b0);
      chk1("zero enc", 1'b1, term_seen[0]);
      wreg(REG_CTRL, 32'h00000000, 1'b0);
   endtask
   task test_combiner;
      logic e;
      wreg(REG_TERM_SEL, tsel(CODE_COMB1, CODE_NONE, CODE_COMB3), 1'b0);
      for (int op = 0; op < 3; op++) begin
         wreg(REG_COMB1, comb(6'h03, 6'h05, 2'(op)), 1'b0);
         for (int v = 0; v < 4; v++) begin
            other[3] <= v[1];
            other[5] <= v[0];
            settle();
            e = (op == 0) ? (v[1] & v[0]) : (op == 1) ? (v[1] | v[0]) : (v[1] ^ v[0]);
            chk1("combiner1", e, term_seen[0]);
         end
      end
      other[0] <= 1'b1;
      settle();
      chk1("combiner3", 1'b1, term_seen[2]);
      wreg(REG_COMB2, comb(6'h21, 6'h00, 2'h0), 1'b1);
      wreg(REG_COMB2, comb(6'h00, 6'h3F, 2'h0), 1'b1);
      wreg(REG_COMB2, comb(6'h00, 6'h00, 2'h3), 1'b1);
      rreg(REG_COMB2, 32'h00000000);
      wreg(REG_COMB2, comb(6'h3E, 6'h20, 2'h1), 1'b0);
      rreg(REG_COMB2, 32'h0001203E);
      wreg(REG_TERM_SEL, tsel(CODE_COMB1, 6'h22, CODE_COMB3), 1'b0);
      settle();
      chk1("combiner2", 1'b0, term_seen[1]);
      other[32] <= 1'b1;
      settle();
      chk1("combiner2", 1'b1, term_seen[1]);
   endtask
   task test_irq;
      drive(16'h0000, 1'b0, 1'b1);
      wreg(REG_IRQ_STATUS, 32'h0000001F, 1'b0);
      rreg(REG_IRQ_STATUS, 32'h00000000);
      chk1("irq", 1'b0, irq_seen);
      wreg(REG_IRQ_MASK, 32'h00000001, 1'b0);
      rreg(REG_IRQ_MASK, 32'h00000001);
      wreg(REG_TERM_SEL, tsel(CODE_OVER_A, CODE_NONE, CODE_NONE), 1'b0);
      drive(16'hFFFF, 1'b1, 1'b0);
      rreg(REG_IRQ_STATUS, 32'h00000003);
      chk1("irq", 1'b1, irq_seen);
      wreg(REG_IRQ_STATUS, 32'h00000001, 1'b0);
      settle();
      chk1("irq", 1'b0, irq_seen);
      rreg(REG_IRQ_STATUS, 32'h00000002);
      rreg(REG_FLAGS, 32'h00000003);
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // =========================================
   // Main sequence and watchdog
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, acc, dec} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      freq = 16'h0000;
      mspeed = 16'h0000;
      other = 64'h0000000000000000;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      test_reset();
      test_overreach();
      test_arrival();
      test_zero();
      test_combiner();
      test_irq();
      tally_and_finish();
   end
   initial begin
      #400000;
      errors++;
      tally_and_finish();
   end
endmodule

bind fao_top fao_checker u_fao_checker (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .out_freq_in(out_freq_in), .motor_speed_in(motor_speed_in),
   .accelerating_in(accelerating_in), .decelerating_in(decelerating_in),
   .other_signals_in(other_signals_in), .terminal_out(terminal_out), .irq_out(irq_out));
